// *** mtpr_cam.sv ***
/* mtpr_cam: camera tap source, one pixel per tap per beat.
 * assumes: bench pulses start with a beat count. */
`timescale 1ns/1ps
module mtpr_cam (
	// clock and reset
	input wire logic                                           pclk,
	input wire logic                                           presetn,
	// bench control
	input wire logic                                           start,
	input wire logic [15:0]                                    count,
	input wire logic                                           slow,
	// tap side
	output logic                                               tap_valid,
	input wire logic                                           tap_ready,
	output logic [mtpr_pkg::NTAP-1:0][mtpr_pkg::PIX_W-1:0]    tap_pixel
);
	import mtpr_pkg::*;
	logic [15:0] left_q; // beats still owed
	logic [15:0] idx_q;  // beats taken so far
	logic        gap_q;  // idle cycle after a beat when slow
	// every tap gives one pixel per beat, held until taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			left_q <= '0;
			idx_q  <= '0;
			gap_q  <= 1'b0;
		end else if (start) begin
			left_q <= count;
			idx_q  <= '0;
		end else begin
			gap_q <= slow && tap_valid && tap_ready;
			if (tap_valid && tap_ready) begin
				left_q <= left_q - 16'h1;
				idx_q  <= idx_q + 16'h1;
			end
		end
	end
	assign tap_valid = (left_q != 16'h0) && !gap_q;
	// idle lanes show the inverse so stale data is never mistaken
	always_comb begin
		for (int l = 0; l < NTAP; l++) tap_pixel[l] = tap_valid ? {4'(l), idx_q[11:0]} : ~{4'(l), idx_q[11:0]};
	end
endmodule : mtpr_cam

// *** mtpr_pkg.sv ***
/*
 * mtpr_pkg: shared constants, register map, field layout, enumerations and
 * carrier structs of the multi-tap pixel reorder block.
 * assumes: one pclk domain; every user of the block imports this package.
 */
package mtpr_pkg;
	// sizes
	localparam int NTAP       = 4;              // tap lanes carried in hardware
	localparam int PIX_W      = 16;             // pixel word width
	localparam int CRD_W      = 16;             // coordinate width, 1-based
	localparam int FIFO_DEPTH = 8;              // beats held before the consumer
	localparam int ADDR_W     = 8;              // apb byte address width
	// register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_LAYOUT = 8'h04;
	localparam logic [ADDR_W-1:0] REG_WIDTH  = 8'h08;
	localparam logic [ADDR_W-1:0] REG_HEIGHT = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] REG_POS    = 8'h14;
	// control field positions
	localparam int CTRL_EN_BIT     = 0;
	localparam int CTRL_ORIENT_LSB = 1;
	localparam int CTRL_LSCAN_BIT  = 3;
	// layout field positions
	localparam int LAY_HZ_LSB = 0;              // 4 bits, horizontal zone count
	localparam int LAY_HG_LSB = 4;              // 4 bits, horizontal group width
	localparam int LAY_HE_LSB = 8;              // 2 bits, horizontal extractor
	localparam int LAY_VZ_LSB = 12;             // 2 bits, vertical zone count
	localparam int LAY_VG_LSB = 16;             // 2 bits, vertical group height
	localparam int LAY_VE_BIT = 20;             // vertical extractor at both ends
	// status field positions
	localparam int STAT_RUN_BIT   = 0;
	localparam int STAT_FAULT_BIT = 1;
	localparam int STAT_FULL_BIT  = 2;
	localparam int STAT_FRM_LSB   = 16;
	// reset values
	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] LAYOUT_RST = 32'h0000_1001;  // single tap, one zone each way
	localparam logic [15:0] WIDTH_RST  = 16'h0040;
	localparam logic [15:0] HEIGHT_RST = 16'h0040;

	// corner holding column one, row one
	typedef enum logic [1:0] {
		MTPR_TOP_LEFT     = 2'h0,
		MTPR_TOP_RIGHT    = 2'h1,
		MTPR_BOTTOM_LEFT  = 2'h2,
		MTPR_BOTTOM_RIGHT = 2'h3
	} mtpr_orient_t;

	// horizontal extractor position
	typedef enum logic [1:0] {
		MTPR_HEXT_LEFT   = 2'h0,
		MTPR_HEXT_ENDS   = 2'h1,
		MTPR_HEXT_MIDDLE = 2'h2
	} mtpr_hext_t;

	// control states
	typedef enum logic [2:0] {
		MTPR_ST_IDLE  = 3'b001,
		MTPR_ST_RUN   = 3'b010,
		MTPR_ST_FAULT = 3'b100
	} mtpr_state_t;

	typedef struct packed {
		mtpr_orient_t     orient;
		logic             line_scan;
		logic [3:0]       hzones;
		logic [3:0]       hgroup;
		mtpr_hext_t       hext;
		logic [1:0]       vzones;
		logic [1:0]       vgroup;
		logic             vext;
		logic [CRD_W-1:0] cols;
		logic [CRD_W-1:0] rows;
	} mtpr_cfg_t;

	typedef struct packed {
		logic [PIX_W-1:0] pixel;
		logic [CRD_W-1:0] col;
		logic [CRD_W-1:0] row;
	} mtpr_lane_t;

	typedef struct packed {
		logic                   sol;       // first beat of a line
		logic                   eol;       // last beat of a line
		logic                   eof;       // last beat of a frame
		logic [NTAP-1:0]        lane_used;
		mtpr_lane_t [NTAP-1:0]  lane;
	} mtpr_beat_t;
endpackage : mtpr_pkg

// *** mtpr_reorder.sv ***
/*
 * mtpr_reorder: tap pixel reorder with apb registers, per-tap coordinate
 * generators and an output fifo; also holds mtpr_fifo and mtpr_tap_coord.
 * assumes: tap streams and consumer run on pclk; apb master on pclk.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// fifo: parameterised width and depth, valid/ready on both sides
module mtpr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];      // storage words
	logic [PW:0]      wr_q;             // write pointer with wrap bit
	logic [PW:0]      rd_q;             // read pointer with wrap bit
	logic             full;
	logic             empty;

	// honest full and empty from pointer compare
	assign empty     = (wr_q == rd_q);
	assign full      = (wr_q[PW-1:0] == rd_q[PW-1:0]) && (wr_q[PW] != rd_q[PW]);
	assign in_ready  = ~full;
	assign out_valid = ~empty & ce;
	assign out_data  = mem[rd_q[PW-1:0]];

	// storage write
	always_ff @(posedge pclk) begin
		if (ce && in_valid && !full) begin
			mem[wr_q[PW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (ce) begin
			if (in_valid && !full) begin
				wr_q <= wr_q + 1'b1;
			end
			if (out_ready && !empty) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule : mtpr_fifo

////////////////////////////////////////////////////////////////////////////////
// per-tap coordinate generator: geometry from layout, then position walk
module mtpr_tap_coord #(
	parameter int LANE = 0
) (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     ce,
	// control
	input  wire mtpr_pkg::mtpr_cfg_t      cfg,
	input  wire logic                     load,
	input  wire logic                     advance,
	input  wire logic                     line_end,
	input  wire logic                     frame_end,
	// position
	output logic [mtpr_pkg::CRD_W-1:0]    col_q,
	output logic [mtpr_pkg::CRD_W-1:0]    row_q,
	output logic                          at_last_col,
	output logic                          at_last_row
);
	import mtpr_pkg::*;
	logic [CRD_W-1:0] first_col, last_col, first_row, last_row;  // geometry
	logic [CRD_W-1:0] col_inc, row_inc;                           // signed steps

	// zone width from zone count, divide by constants only
	function automatic int zone_size(input int n, input logic [3:0] z);
		case (z)
			4'h2:    zone_size = n / 2;
			4'h3:    zone_size = n / 3;
			4'h4:    zone_size = n / 4;
			4'h8:    zone_size = n / 8;
			4'ha:    zone_size = n / 10;
			default: zone_size = n;
		endcase
	endfunction : zone_size

	// geometry of this lane
	always_comb begin
		int txe, tvh, th, hidx, vidx, zone, sub, zw, w, h, fc, lc, ic, fr, lr, ir;
		txe  = (cfg.hgroup == 4'h0) ? 1 : int'(cfg.hgroup);  // no group means one column
		tvh  = (cfg.vgroup == 2'h0) ? 1 : int'(cfg.vgroup);
		th   = int'(cfg.hzones) * txe;
		if (th == 0) begin
			th = 1;
		end
		hidx = LANE % th;                                    // lane order: row first, then column
		vidx = LANE / th;
		zone = hidx / txe;
		sub  = hidx % txe;
		w    = int'(cfg.cols);
		h    = int'(cfg.rows);
		zw   = zone_size(w, cfg.hzones);
		// column walk
		fc = zone * zw + sub + 1;                            // left extractor, interleave k, k+N
		lc = (zone + 1) * zw - txe + sub + 1;
		ic = txe;
		if (cfg.hext == MTPR_HEXT_ENDS && zone == 1) begin
			fc = w - txe + 1 + sub;                          // right half walks leftward
			lc = zw + 1 + sub;
			ic = -txe;
		end else if (cfg.hext == MTPR_HEXT_MIDDLE && zone == 0) begin
			fc = zw - txe + 1 + sub;                         // left half walks out from the middle
			lc = sub + 1;
			ic = -txe;
		end
		// row walk
		if (cfg.line_scan) begin
			fr = 1;                                          // height ignored, rows just count lines
			lr = 0;
			ir = 1;
		end else if (cfg.vzones == 2'h2 && cfg.vext) begin
			fr = (vidx == 0) ? 1 : h;                        // lower taps climb toward the centre
			lr = (vidx == 0) ? h / 2 : h / 2 + 1;
			ir = (vidx == 0) ? 1 : -1;
		end else if (cfg.vzones == 2'h2) begin
			fr = vidx * (h / 2) + 1;
			lr = (vidx + 1) * (h / 2);
			ir = 1;
		end else begin
			fr = vidx + 1;                                   // adjacent row pair
			lr = h - tvh + 1 + vidx;
			ir = tvh;
		end
		first_col = CRD_W'(fc);
		last_col  = CRD_W'(lc);
		col_inc   = CRD_W'(ic);
		first_row = CRD_W'(fr);
		last_row  = CRD_W'(lr);
		row_inc   = CRD_W'(ir);
	end

	assign at_last_col = (col_q == last_col);
	assign at_last_row = (row_q == last_row) && !cfg.line_scan;

	// position walk from first to last pixel by the signed steps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			col_q <= '0;
			row_q <= '0;
		end else if (ce) begin
			if (load) begin
				col_q <= first_col;
				row_q <= first_row;
			end else if (advance) begin
				if (line_end) begin
					col_q <= first_col;
					row_q <= frame_end ? first_row : CRD_W'(row_q + row_inc);
				end else begin
					col_q <= CRD_W'(col_q + col_inc);
				end
			end
		end
	end
endmodule : mtpr_tap_coord

////////////////////////////////////////////////////////////////////////////////
// top: apb registers, control state, lane assembly, output fifo
module mtpr_reorder (
	// clock and reset
	input  wire logic                                    pclk,
	input  wire logic                                    presetn,
	input  wire logic                                    ce,
	// apb slave
	input  wire logic                                    psel,
	input  wire logic                                    penable,
	input  wire logic                                    pwrite,
	input  wire logic [mtpr_pkg::ADDR_W-1:0]             paddr,
	input  wire logic [31:0]                             pwdata,
	output logic [31:0]                                  prdata,
	output logic                                         pready,
	output logic                                         pslverr,
	// camera tap streams, one pixel per lane per beat
	input  wire logic                                    tap_valid,
	output logic                                         tap_ready,
	input  wire logic [mtpr_pkg::NTAP-1:0][mtpr_pkg::PIX_W-1:0] tap_pixel,
	// placed pixel beats toward the image buffer
	output logic                                         out_valid,
	input  wire logic                                    out_ready,
	output mtpr_pkg::mtpr_beat_t                         out_beat
);
	import mtpr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [31:0]      ctrl_q;             // enable, orientation, line mode
	logic [31:0]      layout_q;           // layout code fields
	logic [15:0]      width_q;            // frame columns
	logic [15:0]      height_q;           // frame rows
	logic [31:0]      prdata_q;           // read data captured in setup
	logic [15:0]      frames_q;           // completed frames
	mtpr_state_t      state_q;
	mtpr_cfg_t        cfg_live;           // from registers
	mtpr_cfg_t        cfg_q;              // frozen while running
	logic             cfg_ok;             // layout code is legal
	logic [4:0]       ntaps;              // taps used by the layout
	logic             sol_q;              // next beat opens a line
	logic             load;
	logic             accept;
	logic             line_end;
	logic             frame_end;
	logic             fifo_in_ready;
	logic             fifo_full;
	logic [NTAP-1:0]  last_col, last_row;
	logic [CRD_W-1:0] col [NTAP];
	logic [CRD_W-1:0] row [NTAP];
	mtpr_beat_t       beat_in;
	logic             wr_en, rd_setup, addr_hit;

	////////////////////////////////////////////////////////////////////////////
	// configuration decode and legality
	always_comb begin
		cfg_live.orient    = mtpr_orient_t'(ctrl_q[CTRL_ORIENT_LSB +: 2]);  // reset gives top-left
		cfg_live.line_scan = ctrl_q[CTRL_LSCAN_BIT];
		cfg_live.hzones    = layout_q[LAY_HZ_LSB +: 4];
		cfg_live.hgroup    = layout_q[LAY_HG_LSB +: 4];
		cfg_live.hext      = mtpr_hext_t'(layout_q[LAY_HE_LSB +: 2]);
		cfg_live.vzones    = layout_q[LAY_VZ_LSB +: 2];
		cfg_live.vgroup    = layout_q[LAY_VG_LSB +: 2];
		cfg_live.vext      = layout_q[LAY_VE_BIT];
		cfg_live.cols      = width_q;
		cfg_live.rows      = height_q;
	end

	// legal codes only; more taps than lanes is a fault too
	always_comb begin
		int hz, hg, vz, vg;
		hz     = int'(cfg_live.hzones);
		hg     = (cfg_live.hgroup == 4'h0) ? 1 : int'(cfg_live.hgroup);
		vz     = int'(cfg_live.vzones);
		vg     = (cfg_live.vgroup == 2'h0) ? 1 : int'(cfg_live.vgroup);
		ntaps  = 5'(hz * hg * vz * vg);
		cfg_ok = (hz inside {1, 2, 3, 4, 8, 10})
			&& (cfg_live.hgroup inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h8, 4'ha})
			&& (cfg_live.hext == MTPR_HEXT_LEFT || hz == 2)
			&& (cfg_live.hext != 2'h3)
			&& (vz inside {1, 2})
			&& (cfg_live.vgroup inside {2'h0, 2'h2})
			&& (!cfg_live.vext || vz == 2)
			&& (vz == 1 || cfg_live.vgroup == 2'h0)
			&& (!cfg_live.line_scan || (vz == 1 && cfg_live.vgroup == 2'h0))
			&& (hz * hg * vz * vg <= NTAP)
			&& (width_q != 16'h0000) && (cfg_live.line_scan || height_q != 16'h0000);
	end

	////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, read data captured in setup phase
	assign pready   = ce;
	assign wr_en    = psel && penable && pwrite && ce;
	assign rd_setup = psel && !penable && !pwrite;
	assign addr_hit = paddr inside {REG_CTRL, REG_LAYOUT, REG_WIDTH, REG_HEIGHT, REG_STATUS, REG_POS};
	assign pslverr  = psel && penable && !addr_hit;
	assign prdata   = prdata_q;

	// writable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q   <= CTRL_RST;
			layout_q <= LAYOUT_RST;
			width_q  <= WIDTH_RST;
			height_q <= HEIGHT_RST;
		end else if (wr_en) begin
			case (paddr)
				REG_CTRL:   ctrl_q   <= {28'h0000000, pwdata[3:0]};
				REG_LAYOUT: layout_q <= {11'h000, pwdata[20:0]};
				REG_WIDTH:  width_q  <= pwdata[15:0];
				REG_HEIGHT: height_q <= pwdata[15:0];
				default: ;                                                // status and position are read only
			endcase
		end
	end

	// read mux, unmapped reads as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (ce && rd_setup) begin
			case (paddr)
				REG_CTRL:   prdata_q <= ctrl_q;
				REG_LAYOUT: prdata_q <= layout_q;
				REG_WIDTH:  prdata_q <= {16'h0000, width_q};
				REG_HEIGHT: prdata_q <= {16'h0000, height_q};
				REG_STATUS: prdata_q <= {frames_q, 13'h0000, fifo_full, state_q == MTPR_ST_FAULT,
					state_q == MTPR_ST_RUN};
				REG_POS:    prdata_q <= {row[0], col[0]};
				default:    prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control state: idle until enabled, fault on an illegal layout
	assign load = (state_q == MTPR_ST_IDLE) && ctrl_q[CTRL_EN_BIT] && cfg_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= MTPR_ST_IDLE;
		end else if (ce) begin
			unique case (state_q)
				MTPR_ST_IDLE: begin
					if (ctrl_q[CTRL_EN_BIT]) begin
						state_q <= cfg_ok ? MTPR_ST_RUN : MTPR_ST_FAULT;
					end
				end
				MTPR_ST_RUN, MTPR_ST_FAULT: begin
					if (!ctrl_q[CTRL_EN_BIT]) begin
						state_q <= MTPR_ST_IDLE;
					end
				end
				default: state_q <= MTPR_ST_IDLE;
			endcase
		end
	end

	// snapshot of the layout taken at start, so register writes cannot tear a frame's coordinates; lane_used still follows the live layout register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= '0;
		end else if (ce && load) begin
			cfg_q <= cfg_live;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-tap coordinate generators; all taps carry equal pixel counts, so
	// lane zero alone marks line and frame ends
	assign tap_ready = (state_q == MTPR_ST_RUN) && fifo_in_ready && ce;
	assign accept    = tap_valid && tap_ready;
	assign line_end  = last_col[0];
	assign frame_end = last_col[0] && last_row[0];

	for (genvar l = 0; l < NTAP; l++) begin : g_tap
		mtpr_tap_coord #(.LANE(l)) u_coord (
			.pclk        (pclk),
			.presetn     (presetn),
			.ce          (ce),
			.cfg         (load ? cfg_live : cfg_q),
			.load        (load),
			.advance     (accept),
			.line_end    (line_end),
			.frame_end   (frame_end),
			.col_q       (col[l]),
			.row_q       (row[l]),
			.at_last_col (last_col[l]),
			.at_last_row (last_row[l])
		);
	end

	// line start flag and frame counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sol_q    <= 1'b1;
			frames_q <= 16'h0000;
		end else if (ce) begin
			if (load) begin
				sol_q <= 1'b1;
			end else if (accept) begin
				sol_q <= line_end;
				if (frame_end) begin
					frames_q <= frames_q + 16'h0001;
				end
			end
		end
	end

	// beat assembly with corner flip
	always_comb begin
		logic flip_x, flip_y;
		flip_x            = (cfg_q.orient == MTPR_TOP_RIGHT) || (cfg_q.orient == MTPR_BOTTOM_RIGHT);
		flip_y            = ((cfg_q.orient == MTPR_BOTTOM_LEFT) || (cfg_q.orient == MTPR_BOTTOM_RIGHT))
			&& !cfg_q.line_scan;
		beat_in.sol       = sol_q;
		beat_in.eol       = line_end;
		beat_in.eof       = frame_end;
		beat_in.lane_used = '0;
		for (int l = 0; l < NTAP; l++) begin
			beat_in.lane_used[l]  = (l < int'(ntaps));
			beat_in.lane[l].pixel = tap_pixel[l];
			beat_in.lane[l].col   = flip_x ? CRD_W'(cfg_q.cols + 16'h0001 - col[l]) : col[l];
			beat_in.lane[l].row   = flip_y ? CRD_W'(cfg_q.rows + 16'h0001 - row[l]) : row[l];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output buffer; a stalled consumer fills it and stalls the taps
	mtpr_fifo #(.WIDTH($bits(mtpr_beat_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.in_valid  (accept),
		.in_ready  (fifo_in_ready),
		.in_data   (beat_in),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_beat)
	);
	assign fifo_full = !fifo_in_ready;
endmodule : mtpr_reorder

// *** mtpr_reorder_properties.sv ***
/* mtpr_reorder_properties: port checker for the tap reorder block.
 * assumes: bound to mtpr_reorder, one pclk domain. */
`timescale 1ns/1ps
module mtpr_reorder_properties (
	// clock and reset
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         ce,
	// apb
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [mtpr_pkg::ADDR_W-1:0]  paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	// streams
	input wire logic                         tap_valid,
	input wire logic                         tap_ready,
	input wire logic                         out_valid,
	input wire logic                         out_ready,
	input wire mtpr_pkg::mtpr_beat_t         out_beat
);
	import mtpr_pkg::*;
	logic [CRD_W-1:0] w_q;   // last width written
	logic             sol_q; // a line just closed
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////
	// width shadow from apb writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) w_q <= WIDTH_RST;
		else if (psel && penable && pwrite && pready && paddr == REG_WIDTH) w_q <= pwdata[CRD_W-1:0];
	end
	// remember an accepted end of line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sol_q <= 1'b0;
		else if (out_valid && out_ready) sol_q <= out_beat.eol;
	end
	////////////////////////////////////////////////////////////////////////////
	apb_ready_a: assert property ((psel && penable) |-> pready == ce) else $error("pready not ce");
	err_scope_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
	tap_out_a: assert property ((tap_valid && tap_ready) |=> out_valid) else $error("beat lost");
	beat_hold_a: assert property ((out_valid && !out_ready) |=> out_valid && $stable(out_beat))
		else $error("beat changed while stalled");
	frame_line_a: assert property ((out_valid && out_beat.eof) |-> out_beat.eol) else $error("eof without eol");
	line_start_a: assert property ((out_valid && sol_q) |-> out_beat.sol) else $error("no sol after eol");
	tap_first_a: assert property (out_valid |-> out_beat.lane_used[0]) else $error("first tap unused");
	lanes_low_a: assert property (out_valid |-> (out_beat.lane_used & (out_beat.lane_used + 1)) == 0)
		else $error("used lanes not contiguous");
	col_range_a: assert property (out_valid |-> out_beat.lane[0].col >= 1 && out_beat.lane[0].col <= w_q)
		else $error("column outside width");
	cover property (out_valid && out_ready && out_beat.eof);
	cover property (tap_valid && !tap_ready);
	cover property (pslverr);
endmodule : mtpr_reorder_properties
bind mtpr_reorder mtpr_reorder_properties mtpr_reorder_properties_inst (.pclk(pclk), .presetn(presetn),
	.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .tap_valid(tap_valid), .tap_ready(tap_ready),
	.out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat));

// *** mtpr_reorder_tb_top.sv ***
/* mtpr_reorder_tb_top: self-checking bench for the tap reorder block.
 * assumes: mtpr_cam as tap source, bench as apb master and consumer. */
`timescale 1ns/1ps
module mtpr_reorder_tb_top;
	import mtpr_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, start, slow, rerr;
	logic tap_valid, tap_ready, out_valid, out_ready;
	logic [ADDR_W-1:0]           paddr;
	logic [31:0]                 pwdata, prdata, rdat;
	logic [15:0]                 cnt;
	logic [NTAP-1:0][PIX_W-1:0]  tap_pixel;
	mtpr_beat_t                  out_beat;
	int                          err_total, n_tests;
	mtpr_reorder mtpr_reorder_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tap_valid(tap_valid), .tap_ready(tap_ready), .tap_pixel(tap_pixel), .out_valid(out_valid),
		.out_ready(out_ready), .out_beat(out_beat));
	mtpr_cam mtpr_cam_inst (.pclk(pclk), .presetn(presetn), .start(start), .count(cnt), .slow(slow),
		.tap_valid(tap_valid), .tap_ready(tap_ready), .tap_pixel(tap_pixel));
	always #2 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// apb transfer, held until pready at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// configure, stream n beats, compare every placed pixel
	task run(input logic [31:0] lay, ctl, w, h, input int n, cpl, fpl, input bit hold,
		input int fc[4], cs[4], fr[4], rs[4]);
		int b, t, c, r, col, row;
		apb(1, REG_WIDTH, w);
		apb(1, REG_HEIGHT, h);
		apb(1, REG_LAYOUT, lay);
		apb(1, REG_CTRL, ctl | 32'h1);
		slow <= ~slow;
		cnt <= 16'(n);
		start <= 1'b1;
		@(posedge pclk);
		start <= 1'b0;
		b = 0;
		t = 0;
		while (b < n && t < 3000) begin
			@(posedge pclk);
			t++;
			out_ready <= !(hold && t < 32) && (t % 4 != 3);
			if (hold && t == 31) begin
				apb(0, REG_STATUS, 0);
				chk(rdat[STAT_FULL_BIT], 1);
			end
			@(negedge pclk);
			if (hold && t == 30) chk(tap_ready, 0);
			if (out_valid === 1'b1 && out_ready === 1'b1) begin
				c = b % cpl;
				r = b / cpl;
				chk({out_beat.sol, out_beat.eol, out_beat.eof}, {c == 0, c == cpl - 1, fpl != 0 && (b + 1) % fpl == 0});
				for (int l = 0; l < 4; l++) begin
					chk(out_beat.lane_used[l], fc[l] != 0);
					if (fc[l] != 0) begin
						col = fc[l] + c * cs[l];
						row = fr[l] + r * rs[l];
						if (ctl[1]) col = w + 1 - col;
						if (ctl[2] && !ctl[3]) row = h + 1 - row;
						chk(out_beat.lane[l].pixel, {4'(l), 12'(b)});
						chk(out_beat.lane[l].col, col);
						chk(out_beat.lane[l].row, row);
					end
				end
				b++;
			end
		end
		@(posedge pclk);
		chk(b, n);
		apb(1, REG_CTRL, 0);
		$display("run layout=%h ctrl=%h done", lay, ctl);
	endtask : run
	////////////////////////////////////////////////////////////////////////////
	task t_regs;
		apb(0, REG_CTRL, 0);
		chk(rdat, CTRL_RST);
		apb(0, REG_LAYOUT, 0);
		chk(rdat, LAYOUT_RST);
		apb(0, REG_WIDTH, 0);
		chk(rdat, {16'h0, WIDTH_RST});
		apb(0, REG_HEIGHT, 0);
		chk(rdat, {16'h0, HEIGHT_RST});
		apb(0, 8'h20, 0);
		chk({rdat[30:0], rerr}, 32'h1);
		$display("registers done");
	endtask : t_regs
	task t_orient;
		for (int o = 0; o < 4; o++) run(32'h1001, o << 1, 8, 2, 16, 8, 16, o == 0, '{1,0,0,0}, '{1,1,1,1}, '{1,1,1,1}, '{1,1,1,1});
	endtask : t_orient
	task t_layouts;
		run(32'h1021, 0, 8, 2, 8, 4, 8, 0, '{1,2,0,0}, '{2,2,0,0}, '{1,1,0,0}, '{1,1,0,0});
		run(32'h1102, 0, 8, 2, 8, 4, 8, 0, '{1,8,0,0}, '{1,-1,0,0}, '{1,1,0,0}, '{1,1,0,0});
		run(32'h1202, 0, 8, 2, 8, 4, 8, 0, '{4,5,0,0}, '{-1,1,0,0}, '{1,1,0,0}, '{1,1,0,0});
		run(32'h102001, 4, 8, 4, 16, 8, 16, 0, '{1,1,0,0}, '{1,1,0,0}, '{1,4,0,0}, '{1,-1,0,0});
		run(32'h21001, 0, 8, 4, 16, 8, 16, 0, '{1,1,0,0}, '{1,1,0,0}, '{1,2,0,0}, '{2,2,0,0});
		run(32'h1002, 10, 8, 0, 12, 4, 0, 0, '{1,5,0,0}, '{1,1,0,0}, '{1,1,0,0}, '{1,1,0,0});
	endtask : t_layouts
	task t_codes;
		logic [31:0] lays[19] = '{'h1001, 'h1002, 'h1003, 'h1004, 'h1008, 'h100a, 'h1005, 'h1021, 'h1031,
			'h1041, 'h1081, 'h10a1, 'h1051, 'h1201, 'h3001, 'h11001, 'h21001, 'h101001, 'h10aa};
		logic [1:0] exps[19] = '{1, 1, 1, 1, 2, 2, 2, 1, 1, 1, 2, 2, 2, 2, 2, 2, 1, 2, 2};
		apb(1, REG_HEIGHT, 4);
		apb(0, REG_POS, 0);
		chk(rdat, 32'h0004_0001);
		apb(0, REG_STATUS, 0);
		chk(rdat[31:16], 9);
		for (int i = 0; i < 19; i++) begin
			apb(1, REG_LAYOUT, lays[i]);
			apb(1, REG_CTRL, 1);
			apb(0, REG_STATUS, 0);
			chk(rdat[1:0], exps[i]);
			apb(1, REG_CTRL, 0);
		end
		$display("layout codes done");
	endtask : t_codes
	task print_verdict;
		$display("comparisons=%0d mismatches=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		err_total++;
		print_verdict;
	end
	initial begin
		{pclk, psel, penable, pwrite, start, slow, out_ready, presetn} = '0;
		{paddr, pwdata, cnt, err_total, n_tests} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_orient;
		t_layouts;
		t_codes;
		print_verdict;
	end
endmodule : mtpr_reorder_tb_top
